// ==== hdl/ivam_pkg.sv ====
// package for the interrupt vector address map: variants, vector numbers, widths
`default_nettype none

package ivam_pkg;

	// ========================================
	// device variants
	typedef enum logic [1:0] {
		IVAM_SMALL,
		IVAM_MID,
		IVAM_LARGE
	} ivam_variant_t;

	// ========================================
	// widths
	localparam int ADDR_W   = 14;
	localparam int NUM_IRQ  = 25;
	localparam int VEC_W    = 5;

	// ========================================
	// vector numbers (vector 1 is reset, table index = number - 1)
	localparam logic [VEC_W-1:0] VEC_RESET      = 5'h01;
	localparam logic [VEC_W-1:0] VEC_FIRST_IRQ  = 5'h02;
	localparam logic [VEC_W-1:0] VEC_LAST_IRQ   = 5'h1A;

	// word addresses of table entries with a one-word slot
	localparam logic [ADDR_W-1:0] ADDR_RESET    = 14'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ZERO     = 14'h0000;

	// slot widths in instruction words
	localparam logic [1:0] SLOT_ONE = 2'h1;
	localparam logic [1:0] SLOT_TWO = 2'h2;

	// default boot region start, word address (arbitrary plain default)
	localparam logic [ADDR_W-1:0] BOOT_START_DEF = 14'h1C00;

	// irq bit positions in the request vector (bit i = vector i+2)
	localparam int IRQ_EXT_ZERO      = 0;
	localparam int IRQ_EXT_ONE       = 1;
	localparam int IRQ_PC_ZERO       = 2;
	localparam int IRQ_PC_ONE        = 3;
	localparam int IRQ_PC_TWO        = 4;
	localparam int IRQ_WDOG          = 5;
	localparam int IRQ_TB8_MATCH_A   = 6;
	localparam int IRQ_TB8_MATCH_B   = 7;
	localparam int IRQ_TB8_OVF       = 8;
	localparam int IRQ_TW16_CAPTURE  = 9;
	localparam int IRQ_TW16_MATCH_A  = 10;
	localparam int IRQ_TW16_MATCH_B  = 11;
	localparam int IRQ_TW16_OVF      = 12;
	localparam int IRQ_TA8_MATCH_A   = 13;
	localparam int IRQ_TA8_MATCH_B   = 14;
	localparam int IRQ_TA8_OVF       = 15;
	localparam int IRQ_SPI_DONE      = 16;
	localparam int IRQ_USART_RX      = 17;
	localparam int IRQ_USART_TX_EMPTY = 18;
	localparam int IRQ_USART_TX      = 19;
	localparam int IRQ_ADC_DONE      = 20;
	localparam int IRQ_EEPROM_READY  = 21;
	localparam int IRQ_ANALOG_COMP   = 22;
	localparam int IRQ_TWO_WIRE      = 23;
	localparam int IRQ_STORE_READY   = 24;

endpackage : ivam_pkg

`default_nettype wire

// ==== hdl/ivam_map.sv ====
// vector address map: picks the reset or highest-priority interrupt and forms its fetch address
//
// Overview of operation
// RL1: slot is one word, two on largest
// RL2: smallest variant: reset and table at zero
// RL3: larger variants: fuse picks reset location
// RL4: larger variants: relocate bit picks table base
// RL5: vector 1 at zero serves all resets
// RL6: vectors 2-7: ext irqs, pin changes, watchdog
// RL7: vectors 8-10: second 8-bit timer
// RL8: vectors 11-14: 16-bit timer
// RL9: vectors 15-17: first 8-bit timer
// RL10: vectors 18-21: spi and usart events
// RL11: vectors 22-26: adc, eeprom, comparator, twi, store
// RL12: relocate bit offsets interrupts, not reset
// RL13: fuse 0 boots at boot address
// RL14: reset first, then lowest vector number
// RL15: address = base + index times slot width
`default_nettype none

module ivam_map
	import ivam_pkg::*;
#(
	parameter ivam_pkg::ivam_variant_t        VARIANT    = ivam_pkg::IVAM_LARGE,
	parameter logic [ivam_pkg::ADDR_W-1:0]    BOOT_START = ivam_pkg::BOOT_START_DEF
) (
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	input  wire logic                          reset_req,
	input  wire logic [ivam_pkg::NUM_IRQ-1:0]  irq_req,
	input  wire logic                          boot_reset_fuse,
	input  wire logic                          vector_relocate_bit,
	output var  logic                          vec_valid,
	output var  logic                          vec_is_reset,
	output var  logic [ivam_pkg::VEC_W-1:0]    vec_num,
	output var  logic [ivam_pkg::ADDR_W-1:0]   vec_addr
);
	import ivam_pkg::*;

	// ========================================
	// address arithmetic
	// base plus (number - 1) slots; the multiply is at most by two so it stays a shift
	function automatic logic [ADDR_W-1:0] slot_addr(
		input logic [ADDR_W-1:0] base,
		input logic [VEC_W-1:0]  num,
		input logic [1:0]        slot
	);
		logic [ADDR_W-1:0] idx;
		idx = ADDR_W'(num - VEC_RESET);
		slot_addr = (slot == SLOT_TWO) ? ADDR_W'(base + (idx << 1)) : ADDR_W'(base + idx); // RL15
	endfunction : slot_addr

	// ========================================
	// variant decode
	wire logic              has_boot  = (VARIANT != IVAM_SMALL);                      // RL2
	wire logic [1:0]        slot_w    = (VARIANT == IVAM_LARGE) ? SLOT_TWO : SLOT_ONE; // RL1

	// reset base: the fuse is active low, programmed means boot region
	wire logic [ADDR_W-1:0] reset_base =
		(has_boot && !boot_reset_fuse) ? BOOT_START : ADDR_ZERO;                        // RL3 RL13

	// table base: relocation moves interrupts only, the reset slot keeps reset_base
	wire logic [ADDR_W-1:0] table_base =
		(has_boot && vector_relocate_bit) ? BOOT_START : ADDR_ZERO;                     // RL4 RL12

	// ========================================
	// vector table, one-word slot addresses before scaling and relocation
	//  1 0x000 reset: pin, power-on, brown-out, watchdog system reset
	//  2 0x001 ext_irq_zero
	//  3 0x002 ext_irq_one
	//  4 0x003 pin_change_group_zero
	//  5 0x004 pin_change_group_one
	//  6 0x005 pin_change_group_two
	//  7 0x006 watchdog_timeout_irq
	//  8 0x007 timer_b8_match_a
	//  9 0x008 timer_b8_match_b
	// 10 0x009 timer_b8_overflow
	// 11 0x00A timer_w16_capture
	// 12 0x00B timer_w16_match_a
	// 13 0x00C timer_w16_match_b
	// 14 0x00D timer_w16_overflow
	// 15 0x00E timer_a8_match_a
	// 16 0x00F timer_a8_match_b
	// 17 0x010 timer_a8_overflow
	// 18 0x011 spi_xfer_done
	// 19 0x012 usart_rx_done
	// 20 0x013 usart_tx_buffer_empty
	// 21 0x014 usart_tx_done
	// 22 0x015 converter_done
	// 23 0x016 eeprom_ready_irq
	// 24 0x017 analog_comp_irq
	// 25 0x018 two_wire_serial_irq
	// 26 0x019 program_store_ready_irq

	// placement in the two larger variants:
	//  fuse 1, relocate 0: reset at zero, table at zero
	//  fuse 1, relocate 1: reset at zero, table at boot start
	//  fuse 0, relocate 0: reset at boot start, table at zero
	//  fuse 0, relocate 1: reset and table at boot start
	// mixed settings leave unused table slots free for plain code

	// ========================================
	// request sources by name; each line pins one source to its slot
	// external lines, pin changes and the watchdog time-out
	wire logic ext_irq_zero            = irq_req[IRQ_EXT_ZERO];       // RL6
	wire logic ext_irq_one             = irq_req[IRQ_EXT_ONE];        // RL6
	wire logic pin_change_group_zero   = irq_req[IRQ_PC_ZERO];        // RL6
	wire logic pin_change_group_one    = irq_req[IRQ_PC_ONE];         // RL6
	wire logic pin_change_group_two    = irq_req[IRQ_PC_TWO];         // RL6
	wire logic watchdog_timeout_irq    = irq_req[IRQ_WDOG];           // RL6

	// second 8-bit timer
	wire logic timer_b8_match_a        = irq_req[IRQ_TB8_MATCH_A];    // RL7
	wire logic timer_b8_match_b        = irq_req[IRQ_TB8_MATCH_B];    // RL7
	wire logic timer_b8_overflow       = irq_req[IRQ_TB8_OVF];        // RL7

	// 16-bit timer
	wire logic timer_w16_capture       = irq_req[IRQ_TW16_CAPTURE];   // RL8
	wire logic timer_w16_match_a       = irq_req[IRQ_TW16_MATCH_A];   // RL8
	wire logic timer_w16_match_b       = irq_req[IRQ_TW16_MATCH_B];   // RL8
	wire logic timer_w16_overflow      = irq_req[IRQ_TW16_OVF];       // RL8

	// first 8-bit timer
	wire logic timer_a8_match_a        = irq_req[IRQ_TA8_MATCH_A];    // RL9
	wire logic timer_a8_match_b        = irq_req[IRQ_TA8_MATCH_B];    // RL9
	wire logic timer_a8_overflow       = irq_req[IRQ_TA8_OVF];        // RL9

	// serial units
	wire logic spi_xfer_done           = irq_req[IRQ_SPI_DONE];       // RL10
	wire logic usart_rx_done           = irq_req[IRQ_USART_RX];       // RL10
	wire logic usart_tx_buffer_empty   = irq_req[IRQ_USART_TX_EMPTY]; // RL10
	wire logic usart_tx_done           = irq_req[IRQ_USART_TX];       // RL10

	// converter, eeprom, comparator, two-wire and program store
	wire logic converter_done          = irq_req[IRQ_ADC_DONE];       // RL11
	wire logic eeprom_ready_irq        = irq_req[IRQ_EEPROM_READY];   // RL11
	wire logic analog_comp_irq         = irq_req[IRQ_ANALOG_COMP];    // RL11
	wire logic two_wire_serial_irq     = irq_req[IRQ_TWO_WIRE];       // RL11
	wire logic program_store_ready_irq = irq_req[IRQ_STORE_READY];    // RL11

	// ordered request vector, lowest vector number in bit 0
	wire logic [NUM_IRQ-1:0] ordered_req = {
		program_store_ready_irq,
		two_wire_serial_irq,
		analog_comp_irq,
		eeprom_ready_irq,
		converter_done,
		usart_tx_done,
		usart_tx_buffer_empty,
		usart_rx_done,
		spi_xfer_done,
		timer_a8_overflow,
		timer_a8_match_b,
		timer_a8_match_a,
		timer_w16_overflow,
		timer_w16_match_b,
		timer_w16_match_a,
		timer_w16_capture,
		timer_b8_overflow,
		timer_b8_match_b,
		timer_b8_match_a,
		watchdog_timeout_irq,
		pin_change_group_two,
		pin_change_group_one,
		pin_change_group_zero,
		ext_irq_one,
		ext_irq_zero
	};

	// ========================================
	// priority: lowest bit (lowest vector number) wins; the loop runs downwards
	// so the last hit is the lowest set bit, vectors 2..26 for bits 0..24
	logic [VEC_W-1:0] pick_num;
	logic             pick_any;
	always_comb begin
		pick_num = VEC_RESET;
		pick_any = 1'b0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (ordered_req[i]) begin
				pick_num = VEC_W'(i + 2); // RL14
				pick_any = 1'b1;
			end
		end
	end

	// reset outranks any interrupt
	wire logic              next_valid    = reset_req || pick_any;               // RL14
	wire logic              next_is_reset = reset_req;
	wire logic [VEC_W-1:0]  next_num      = reset_req ? VEC_RESET : pick_num;    // RL5 RL14
	wire logic [ADDR_W-1:0] next_addr     = reset_req ?
		ADDR_W'(reset_base + ADDR_RESET) :                                      // RL5
		slot_addr(table_base, pick_num, slot_w);                                // RL15

	// ========================================
	// registered outputs, one cycle after the request

	// offer flag; the core fetches only while it is high
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vec_valid <= 1'b0;
		end else begin
			vec_valid <= next_valid;
		end
	end

	// reset marker, so the core can tell a restart from a call
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vec_is_reset <= 1'b0;
		end else begin
			vec_is_reset <= next_is_reset;
		end
	end

	// vector number, zero when nothing is offered
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vec_num <= '0;
		end else begin
			vec_num <= next_valid ? next_num : '0;
		end
	end

	// fetch address, zero when nothing is offered
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vec_addr <= '0;
		end else begin
			vec_addr <= next_valid ? next_addr : '0;
		end
	end

endmodule : ivam_map

`default_nettype wire

// ==== bench/ivam_map_props.sv ====
// assertions on the vector address map ports
`default_nettype none
module ivam_map_props
	import ivam_pkg::*;
#(
	parameter ivam_variant_t      VARIANT    = IVAM_LARGE,
	parameter logic [ADDR_W-1:0]  BOOT_START = BOOT_START_DEF
) (
	input wire logic               core_clk,
	input wire logic               nrst,
	input wire logic               reset_req,
	input wire logic [NUM_IRQ-1:0] irq_req,
	input wire logic               boot_reset_fuse,
	input wire logic               vector_relocate_bit,
	input wire logic               vec_valid,
	input wire logic               vec_is_reset,
	input wire logic [VEC_W-1:0]   vec_num,
	input wire logic [ADDR_W-1:0]  vec_addr
);
	// smallest variant has no boot region; largest uses two-word slots
	localparam logic [ADDR_W-1:0] BOOT_BASE = (VARIANT == IVAM_SMALL) ? 14'h0000 : BOOT_START;
	localparam int                SLOT      = (VARIANT == IVAM_LARGE) ? 2 : 1;
	// ==========
	// one cycle from request to vector
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_reset_vec: assert property (reset_req |=> vec_is_reset && vec_num == 1) else $error("rst");
	a_reset_home: assert property (reset_req && boot_reset_fuse |=> vec_addr == 0) else $error("rh");
	a_reset_boot: assert property (reset_req && !boot_reset_fuse |=> vec_addr == BOOT_BASE)
		else $error("rb");
	a_idle_clear: assert property (!reset_req && irq_req == 0 |=> {vec_valid, vec_num, vec_addr} == 0)
		else $error("idle");
	a_first_irq: assert property (!reset_req && irq_req[0] |=> vec_num == 2) else $error("pri");
	a_wdog_num: assert property (!reset_req && irq_req[5:0] == 6'h20 |=> vec_num == 7) else $error("wd");
	a_last_irq: assert property (!reset_req && irq_req == 25'h1000000 |=> vec_num == 26) else $error("l");
	a_irq_addr: assert property (!reset_req && |irq_req |=> vec_valid && !vec_is_reset &&
		vec_addr == ($past(vector_relocate_bit) ? BOOT_BASE : 0) + SLOT * (vec_num - 1))
		else $error("addr");
endmodule : ivam_map_props
bind ivam_map ivam_map_props #(.VARIANT(VARIANT), .BOOT_START(BOOT_START)) u_props (.*);
`default_nettype wire

// ==== bench/ivam_core_model.sv ====
// core model: takes the offered vector as its next fetch
`default_nettype none
module ivam_core_model (
	input wire logic        vec_valid,
	input wire logic [13:0] vec_addr,
	output logic            fetch_en,
	output logic [13:0]     fetch_addr
);
	// no fetch without a vector, so the address reads zero then
	assign fetch_en = vec_valid;
	assign fetch_addr = vec_valid ? vec_addr : 14'h0000;
endmodule : ivam_core_model
`default_nettype wire

// ==== bench/testbench.sv ====
// random bench for the vector address map, all three variants
`default_nettype none
module testbench
	import ivam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, nrst = 0, reset_req = 0, boot_reset_fuse = 1, vector_relocate_bit = 0;
	logic rr, ff, vv, fetch_en, vec_valid, vec_is_reset;
	logic [NUM_IRQ-1:0] irq_req = 0, qq;
	logic [VEC_W-1:0] vec_num;
	logic [ADDR_W-1:0] vec_addr, fetch_addr;
	logic [20:0] exp_q[$], exp_mid[$], exp_small[$];
	logic mid_valid, mid_is_reset, small_valid, small_is_reset;
	logic [VEC_W-1:0] mid_num, small_num;
	logic [ADDR_W-1:0] mid_addr, small_addr;
	int mismatches = 0, check_count = 0, i;
	integer seed = 32'h528b;
	always #20 core_clk = ~core_clk;
	ivam_map dut (.core_clk(core_clk), .nrst(nrst), .reset_req(reset_req), .irq_req(irq_req),
		.boot_reset_fuse(boot_reset_fuse), .vector_relocate_bit(vector_relocate_bit),
		.vec_valid(vec_valid), .vec_is_reset(vec_is_reset), .vec_num(vec_num), .vec_addr(vec_addr));
	ivam_core_model core (.vec_valid(vec_valid), .vec_addr(vec_addr), .fetch_en(fetch_en),
		.fetch_addr(fetch_addr));
	// the two other variants see the same requests
	ivam_map #(.VARIANT(IVAM_MID)) dut_mid (.core_clk(core_clk), .nrst(nrst),
		.reset_req(reset_req), .irq_req(irq_req), .boot_reset_fuse(boot_reset_fuse),
		.vector_relocate_bit(vector_relocate_bit), .vec_valid(mid_valid),
		.vec_is_reset(mid_is_reset), .vec_num(mid_num), .vec_addr(mid_addr));
	ivam_map #(.VARIANT(IVAM_SMALL)) dut_small (.core_clk(core_clk), .nrst(nrst),
		.reset_req(reset_req), .irq_req(irq_req), .boot_reset_fuse(boot_reset_fuse),
		.vector_relocate_bit(vector_relocate_bit), .vec_valid(small_valid),
		.vec_is_reset(small_is_reset), .vec_num(small_num), .vec_addr(small_addr));
	task automatic check(input string name, input logic [20:0] seen, input logic [20:0] expd);
		check_count++;
		if (seen !== expd) begin
			mismatches++;
			$display("[ERR] %s exp=%h seen=%h", name, expd, seen);
		end
	endtask : check
	// expected {valid, is_reset, number, address} from the table rules
	function automatic logic [20:0] exp_of(input logic r, input logic f, input logic v,
		input logic [NUM_IRQ-1:0] q, input int slot, input logic boot);
		exp_of = 21'h000000;
		for (int n = NUM_IRQ - 1; n >= 0; n--) begin
			if (q[n]) exp_of = {2'b10, 5'(n + 2), 14'(((boot && v) ? BOOT_START_DEF : 0) + slot * (n + 1))};
		end
		if (r) exp_of = {2'b11, VEC_RESET, (boot && !f) ? BOOT_START_DEF : ADDR_ZERO};
	endfunction : exp_of
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	// ==========
	// random requests; a note of the expected vector per cycle
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		for (i = 0; i < 600; i++) begin
			@(posedge core_clk);
			rr = ($random(seed) & 7) == 0;
			ff = 1'($random(seed));
			vv = 1'($random(seed));
			qq = 25'(($random(seed) & $random(seed)) << (($random(seed) & 31) % 25));
			exp_q.push_back(exp_of(rr, ff, vv, qq, 2, 1'b1));
			exp_mid.push_back(exp_of(rr, ff, vv, qq, 1, 1'b1));
			exp_small.push_back(exp_of(rr, ff, vv, qq, 1, 1'b0));
			{reset_req, boot_reset_fuse, vector_relocate_bit, irq_req} <= {rr, ff, vv, qq};
		end
		repeat (2) @(posedge core_clk);
		test_done();
	end
	// settled outputs answer the note of the cycle before
	always @(negedge core_clk) begin
		if (exp_q.size() > 1) begin
			check("large", {fetch_en, vec_is_reset, vec_num, fetch_addr}, exp_q.pop_front());
			check("mid", {mid_valid, mid_is_reset, mid_num, mid_addr}, exp_mid.pop_front());
			check("small", {small_valid, small_is_reset, small_num, small_addr},
				exp_small.pop_front());
		end
	end
	// hang guard well past the run length
	initial begin
		#40000;
		mismatches++;
		test_done();
	end
endmodule : testbench
`default_nettype wire
